/* pkg/rpm_pkg.sv */
// Constants and types for the reference clock, interrupt and pin mux block
package rpm_pkg;
  localparam logic [4:0] ADDR_ICSR = 5'h1b;
  localparam logic [4:0] ADDR_CTL2 = 5'h1f;
  localparam logic [4:0] PHY_ADDR = 5'h00;
  localparam int CTL_CLK_MODE = 7;
  localparam int CTL_INT_POL = 9;
  localparam int CTL_WAKE_OPT2 = 10;
  localparam int CTL_NAND = 11;
  localparam logic [15:0] CTL2_RST = 16'h0000;
  localparam logic [7:0] ICSR_RST = 8'h00;
  localparam logic [5:0] PRE_ONES = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'h0c;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam int SYS_HZ = 100_000_000;
  localparam int REF_HZ = 50_000_000;
  localparam logic [3:0] REF_HALF = 4'(SYS_HZ / REF_HZ / 2);
  localparam int PIN_TXEN = 0;
  localparam int PIN_TXD0 = 1;
  localparam int PIN_TXD1 = 2;
  localparam int PIN_RECEIVE_ERROR_OUT = 3;
  localparam int PIN_VARIANT = 4;
  localparam int PIN_N = 5;
  localparam int NAND_N = 3;
  typedef enum logic [1:0] {
    MD_IDLE = 2'b00,
    MD_HDR = 2'b01,
    MD_TA = 2'b10,
    MD_DATA = 2'b11
  } rpm_mdio_e;
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] data;
  } rpm_wr_s;
  typedef struct packed {
    logic en;
    logic [1:0] data;
  } rpm_tx_s;
endpackage : rpm_pkg

/* core/rpm_pin_mux.sv */
// Reference clock, receive error, interrupt/wake and transmit pin logic
// Function
// - 25 MHz mode drives 50 MHz reference out
// - 50 MHz mode leaves reference pin undriven
// - Crystal variant starts in 25 MHz mode
// - External clock variant starts in 50 MHz
// - Control bit 7 of 1Fh selects clock mode
// - Receive errors reach the MAC on pin
// - Receive error strap latched as wake enable
// - Interrupt follows enabled causes in 1Bh
// - Bit 9 of 1Fh sets interrupt polarity
// - Wake option two drives interrupt pin low
// - NAND tree mode makes TXD1 an output
// - Registers reached over management clock and data
module rpm_pin_mux (
  // System clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Management interface
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // Reference clock
  input wire logic clock_variant_in,
  output logic ref_clk_out,
  output logic ref_clk_oe_out,
  // Receive error and wake strap
  input wire logic rx_error_in,
  input wire logic receive_error_out_pin_in,
  output logic receive_error_out,
  output logic receive_error_oe_out,
  output logic wake_output_enable_strap_out,
  // Interrupt and wake
  input wire logic [7:0] event_in,
  input wire logic wake_event_in,
  output logic interrupt_pin_out,
  output logic interrupt_pin_oe_out,
  // Transmit pins
  input wire logic txen_in,
  input wire logic txd0_in,
  input wire logic txd1_in,
  output logic txd1_out,
  output logic txd1_oe_out,
  output rpm_pkg::rpm_tx_s tx_out
);
  import rpm_pkg::*;

  // Pin synchronisers with agreement filter
  logic [PIN_N-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_q_ff, nxt_pin_q;
  logic [NAND_N:0] nand_chain;
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin
      always_comb begin
        nxt_pin_q[gi] = (pin_s2_ff[gi] == pin_s3_ff[gi]) ? pin_s3_ff[gi] : pin_q_ff[gi];
      end
    end
    for (gi = 0; gi < NAND_N; gi++) begin : g_nand
      assign nand_chain[gi+1] = ~(nand_chain[gi] & pin_q_ff[gi]);
    end
  endgenerate
  assign nand_chain[0] = 1'b1;
  always_ff @(posedge clk_in) begin
    pin_s1_ff <= {clock_variant_in, receive_error_out_pin_in, txd1_in, txd0_in, txen_in};
    pin_s2_ff <= pin_s1_ff;
    pin_s3_ff <= pin_s2_ff;
    pin_q_ff <= nxt_pin_q;
  end

  // Crossings from the management domain
  logic [1:0] x_s1_ff, x_s2_ff, x_s3_ff;
  logic wr_tgl_ff, rc_tgl_ff;
  rpm_wr_s wr_ff;
  logic [7:0] rc_snap_ff;
  logic wr_edge, rc_edge;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      x_s1_ff <= 2'h0;
      x_s2_ff <= 2'h0;
      x_s3_ff <= 2'h0;
    end else begin
      x_s1_ff <= {rc_tgl_ff, wr_tgl_ff};
      x_s2_ff <= x_s1_ff;
      x_s3_ff <= x_s2_ff;
    end
  end
  assign wr_edge = x_s2_ff[0] ^ x_s3_ff[0];
  assign rc_edge = x_s2_ff[1] ^ x_s3_ff[1];

  // Register file
  logic rst_q_ff, release_now;
  logic [15:0] ctl_ff, nxt_ctl;
  logic [7:0] en_ff, nxt_en, st_ff, nxt_st;
  logic wake_ff, nxt_wake, wake_en_ff, nxt_wake_en, int_act;
  assign release_now = !rst_q_ff && resetn_in;
  assign int_act = |(st_ff & en_ff);
  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_en = en_ff;
    nxt_wake_en = wake_en_ff;
    if (release_now) begin
      nxt_ctl[CTL_CLK_MODE] = pin_q_ff[PIN_VARIANT];
      nxt_wake_en = pin_q_ff[PIN_RECEIVE_ERROR_OUT];
    end
    if (wr_edge && wr_ff.addr == ADDR_CTL2) nxt_ctl = wr_ff.data;
    if (wr_edge && wr_ff.addr == ADDR_ICSR) nxt_en = wr_ff.data[15:8];
    nxt_st = (st_ff & ~(rc_edge ? rc_snap_ff : 8'h00)) | event_in;
    nxt_wake = (wake_ff && !rc_edge) || wake_event_in;
  end
  always_ff @(posedge clk_in) begin
    rst_q_ff <= resetn_in;
    if (!resetn_in) begin
      ctl_ff <= CTL2_RST;
      en_ff <= ICSR_RST;
      st_ff <= ICSR_RST;
      wake_ff <= 1'b0;
      wake_en_ff <= 1'b0;
    end else begin
      ctl_ff <= nxt_ctl;
      en_ff <= nxt_en;
      st_ff <= nxt_st;
      wake_ff <= nxt_wake;
      wake_en_ff <= nxt_wake_en;
    end
  end

  // Output pins
  logic [3:0] ref_cnt_ff, nxt_ref_cnt;
  logic nxt_ref, nxt_ref_oe, nxt_receive_error_out, nxt_receive_error_out_oe, nxt_int, nxt_int_oe;
  logic nxt_txd1, nxt_txd1_oe;
  rpm_tx_s nxt_tx;
  always_comb begin
    nxt_ref_cnt = ref_cnt_ff + 4'h1;
    nxt_ref = ref_clk_out;
    if (ref_cnt_ff == REF_HALF - 4'h1) begin
      nxt_ref_cnt = 4'h0;
      nxt_ref = !ref_clk_out;
    end
    // Pin stays off in the release cycle until the strapped mode has landed
    nxt_ref_oe = !ctl_ff[CTL_CLK_MODE] && !release_now;
    if (ctl_ff[CTL_CLK_MODE] || release_now) nxt_ref = 1'b0;
    nxt_receive_error_out = rx_error_in;
    nxt_receive_error_out_oe = 1'b1;
    if (ctl_ff[CTL_WAKE_OPT2] && wake_en_ff) begin
      nxt_int = 1'b0;
      nxt_int_oe = wake_ff;
    end else if (ctl_ff[CTL_INT_POL]) begin
      nxt_int = int_act;
      nxt_int_oe = 1'b1;
    end else begin
      nxt_int = 1'b0;
      nxt_int_oe = int_act;
    end
    nxt_txd1_oe = ctl_ff[CTL_NAND];
    nxt_txd1 = ctl_ff[CTL_NAND] ? nand_chain[NAND_N] : 1'b0;
    nxt_tx.en = pin_q_ff[PIN_TXEN];
    nxt_tx.data = {ctl_ff[CTL_NAND] ? 1'b0 : pin_q_ff[PIN_TXD1], pin_q_ff[PIN_TXD0]};
  end
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ref_cnt_ff <= 4'h0;
      ref_clk_out <= 1'b0;
      ref_clk_oe_out <= 1'b0;
      receive_error_out <= 1'b0;
      receive_error_oe_out <= 1'b0;
      interrupt_pin_out <= 1'b0;
      interrupt_pin_oe_out <= 1'b0;
      txd1_out <= 1'b0;
      txd1_oe_out <= 1'b0;
      tx_out <= '0;
      wake_output_enable_strap_out <= 1'b0;
    end else begin
      ref_cnt_ff <= nxt_ref_cnt;
      ref_clk_out <= nxt_ref;
      ref_clk_oe_out <= nxt_ref_oe;
      receive_error_out <= nxt_receive_error_out;
      receive_error_oe_out <= nxt_receive_error_out_oe;
      interrupt_pin_out <= nxt_int;
      interrupt_pin_oe_out <= nxt_int_oe;
      txd1_out <= nxt_txd1;
      txd1_oe_out <= nxt_txd1_oe;
      tx_out <= nxt_tx;
      wake_output_enable_strap_out <= wake_en_ff;
    end
  end

  // Management frame engine on the management clock
  logic mr_s1_ff, mr_s2_ff, mrst;
  logic [15:0] icsr_s1_ff, icsr_s2_ff, ctl_s1_ff, ctl_s2_ff, rd_word;
  rpm_mdio_e md_ff, nxt_md;
  logic [5:0] pre_ff, nxt_pre;
  logic [4:0] cnt_ff, nxt_cnt, reg_ff, nxt_reg;
  logic [15:0] sh_ff, nxt_sh;
  logic [12:0] hdr;
  logic rd_ff, nxt_rd, nxt_mo, nxt_moe, nxt_wr_tgl, nxt_rc_tgl;
  rpm_wr_s nxt_wr;
  logic [7:0] nxt_rc_snap;
  assign mrst = !mr_s2_ff;
  assign hdr = {sh_ff[11:0], mdio_in};
  always_ff @(posedge mdc_in) begin
    mr_s1_ff <= resetn_in;
    mr_s2_ff <= mr_s1_ff;
    icsr_s1_ff <= {en_ff, st_ff};
    icsr_s2_ff <= icsr_s1_ff;
    ctl_s1_ff <= ctl_ff;
    ctl_s2_ff <= ctl_s1_ff;
  end
  always_comb begin
    if (hdr[4:0] == ADDR_ICSR) rd_word = icsr_s2_ff;
    else if (hdr[4:0] == ADDR_CTL2) rd_word = ctl_s2_ff;
    else rd_word = 16'h0000;
  end
  always_comb begin
    nxt_md = md_ff;
    nxt_pre = pre_ff;
    nxt_cnt = cnt_ff + 5'h01;
    nxt_reg = reg_ff;
    nxt_sh = sh_ff;
    nxt_rd = rd_ff;
    nxt_mo = mdio_out;
    nxt_moe = mdio_oe_out;
    nxt_wr = wr_ff;
    nxt_wr_tgl = wr_tgl_ff;
    nxt_rc_tgl = rc_tgl_ff;
    nxt_rc_snap = rc_snap_ff;
    case (md_ff)
      MD_IDLE: begin
        nxt_cnt = 5'h00;
        if (mdio_in) begin
          if (pre_ff != PRE_ONES) nxt_pre = pre_ff + 6'h01;
        end else begin
          if (pre_ff == PRE_ONES) nxt_md = MD_HDR;
          nxt_pre = 6'h00;
        end
      end
      MD_HDR: begin
        nxt_sh = {sh_ff[14:0], mdio_in};
        if (cnt_ff == HDR_LAST) begin
          nxt_cnt = 5'h00;
          nxt_reg = hdr[4:0];
          nxt_rd = hdr[11:10] == OP_READ;
          nxt_md = MD_IDLE;
          if (hdr[12] && hdr[9:5] == PHY_ADDR &&
              (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE)) begin
            nxt_md = MD_TA;
            if (hdr[11:10] == OP_READ) begin
              nxt_sh = rd_word;
              if (hdr[4:0] == ADDR_ICSR) begin
                nxt_rc_snap = icsr_s2_ff[7:0];
                nxt_rc_tgl = !rc_tgl_ff;
              end
            end
          end
        end
      end
      MD_TA: begin
        if (rd_ff) begin
          nxt_moe = 1'b1;
          nxt_mo = 1'b0;
          if (cnt_ff != 5'h00) begin
            nxt_mo = sh_ff[15];
            nxt_sh = {sh_ff[14:0], 1'b0};
          end
        end
        if (cnt_ff != 5'h00) begin
          nxt_cnt = 5'h00;
          nxt_md = MD_DATA;
        end
      end
      MD_DATA: begin
        if (rd_ff) begin
          nxt_mo = sh_ff[15];
          nxt_sh = {sh_ff[14:0], 1'b0};
        end else begin
          nxt_sh = {sh_ff[14:0], mdio_in};
        end
        if (cnt_ff == DATA_LAST) begin
          nxt_md = MD_IDLE;
          nxt_moe = 1'b0;
          nxt_mo = 1'b0;
          if (!rd_ff) begin
            nxt_wr.addr = reg_ff;
            nxt_wr.data = {sh_ff[14:0], mdio_in};
            nxt_wr_tgl = !wr_tgl_ff;
          end
        end
      end
      default: nxt_md = MD_IDLE;
    endcase
  end
  always_ff @(posedge mdc_in) begin
    if (mrst) begin
      md_ff <= MD_IDLE;
      pre_ff <= 6'h00;
      cnt_ff <= 5'h00;
      reg_ff <= 5'h00;
      sh_ff <= 16'h0000;
      rd_ff <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe_out <= 1'b0;
      wr_ff <= '0;
      wr_tgl_ff <= 1'b0;
      rc_tgl_ff <= 1'b0;
      rc_snap_ff <= 8'h00;
    end else begin
      md_ff <= nxt_md;
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
      reg_ff <= nxt_reg;
      sh_ff <= nxt_sh;
      rd_ff <= nxt_rd;
      mdio_out <= nxt_mo;
      mdio_oe_out <= nxt_moe;
      wr_ff <= nxt_wr;
      wr_tgl_ff <= nxt_wr_tgl;
      rc_tgl_ff <= nxt_rc_tgl;
      rc_snap_ff <= nxt_rc_snap;
    end
  end

  // Checks
  property p_ref_run;
    @(posedge clk_in) disable iff (!resetn_in)
    (ref_clk_oe_out && $past(ref_clk_oe_out, 2)) |-> ref_clk_out != $past(ref_clk_out);
  endproperty
  a_ref_run: assert property (p_ref_run) else $error("ref clock stalled");
  property p_ref_off;
    @(posedge clk_in) disable iff (!resetn_in)
    ctl_ff[CTL_CLK_MODE] |=> !ref_clk_oe_out && !ref_clk_out;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("ref pin driven in 50 MHz mode");
  property p_strap_mode;
    @(posedge clk_in) disable iff (!resetn_in)
    release_now |=> ctl_ff[CTL_CLK_MODE] == $past(pin_q_ff[PIN_VARIANT]);
  endproperty
  a_strap_mode: assert property (p_strap_mode) else $error("clock mode strap lost");
  property p_ext_quiet;
    @(posedge clk_in) disable iff (!resetn_in)
    (release_now && pin_q_ff[PIN_VARIANT] && !wr_edge) |=> !ref_clk_oe_out ##1 !ref_clk_oe_out;
  endproperty
  a_ext_quiet: assert property (p_ext_quiet) else $error("external variant drives ref");
  property p_wr_ctl;
    @(posedge clk_in) disable iff (!resetn_in)
    (wr_edge && wr_ff.addr == ADDR_CTL2) |=> ctl_ff == $past(wr_ff.data);
  endproperty
  a_wr_ctl: assert property (p_wr_ctl) else $error("control write lost");
  property p_receive_error_out;
    @(posedge clk_in) disable iff (!resetn_in)
    rst_q_ff |=> receive_error_oe_out && receive_error_out == $past(rx_error_in);
  endproperty
  a_receive_error_out: assert property (p_receive_error_out) else $error("receive error not forwarded");
  property p_wake_strap;
    @(posedge clk_in) disable iff (!resetn_in)
    release_now |=> ##1 wake_output_enable_strap_out == $past(pin_q_ff[PIN_RECEIVE_ERROR_OUT], 2);
  endproperty
  a_wake_strap: assert property (p_wake_strap) else $error("wake strap lost");
  property p_int_low;
    @(posedge clk_in) disable iff (!resetn_in)
    (int_act && !ctl_ff[CTL_INT_POL] && !ctl_ff[CTL_WAKE_OPT2])
      |=> interrupt_pin_oe_out && !interrupt_pin_out;
  endproperty
  a_int_low: assert property (p_int_low) else $error("interrupt not asserted");
  property p_int_pol;
    @(posedge clk_in) disable iff (!resetn_in)
    (ctl_ff[CTL_INT_POL] && !ctl_ff[CTL_WAKE_OPT2]) |=> interrupt_pin_out == $past(int_act);
  endproperty
  a_int_pol: assert property (p_int_pol) else $error("interrupt polarity wrong");
  property p_wake_two;
    @(posedge clk_in) disable iff (!resetn_in)
    (ctl_ff[CTL_WAKE_OPT2] && wake_en_ff && wake_ff)
      |=> interrupt_pin_oe_out && !interrupt_pin_out;
  endproperty
  a_wake_two: assert property (p_wake_two) else $error("wake not signalled");
  property p_nand;
    @(posedge clk_in) disable iff (!resetn_in)
    ctl_ff[CTL_NAND] |=> txd1_oe_out && !tx_out.data[1];
  endproperty
  a_nand: assert property (p_nand) else $error("nand tree output missing");
  property p_int_hold;
    @(posedge clk_in) disable iff (!resetn_in)
    (int_act && !rc_edge && !wr_edge) |=> int_act;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt dropped early");
  property p_ta;
    @(posedge mdc_in) disable iff (mrst)
    (md_ff == MD_TA && rd_ff && cnt_ff == 5'h00) |=> mdio_oe_out && !mdio_out;
  endproperty
  a_ta: assert property (p_ta) else $error("turnaround zero missing");
endmodule : rpm_pin_mux

/* dv/rpm_mac_model.sv */
// MAC side model: management master and transmit pin driver
module rpm_mac_model (
  // Management
  output logic mdc_out,
  output logic mac_mdio_out,
  output logic mac_oe_out,
  input wire logic mdio_in,
  // Transmit
  output rpm_pkg::rpm_tx_s tx_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import rpm_pkg::*;

  // Clock stands still and the wire is released outside frames
  initial begin
    mdc_out = 1'b0;
    mac_mdio_out = 1'b1;
    mac_oe_out = 1'b0;
    tx_out = '0;
  end

  // One 6 ns management period, wire sampled just before the rise
  task automatic tick(output logic smp);
    #3 smp = mdio_in;
    mdc_out = 1'b1;
    #3 mdc_out = 1'b0;
  endtask : tick

  task automatic pulses(input int n);
    logic s;
    repeat (n) tick(s);
  endtask : pulses

  // Full frame with its own preamble, MSB first
  task automatic frame(input logic [1:0] op, input logic [4:0] regad,
      input logic [15:0] wdat, output logic [15:0] rdat);
    logic [63:0] bits;
    logic s;
    bits = {32'hffffffff, 2'b01, op, PHY_ADDR, regad, 2'b10, wdat};
    rdat = '0;
    mac_oe_out = 1'b1;
    for (int i = 63; i >= 0; i--) begin
      mac_mdio_out = bits[i];
      if (op == OP_READ && i < 18) begin
        mac_oe_out = 1'b0;
      end
      tick(s);
      if (i < 16) begin
        rdat[i] = s;
      end
    end
    mac_oe_out = 1'b0;
    mac_mdio_out = 1'b1;
  endtask : frame

  // Transmit enable and data from the MAC
  task automatic send(input rpm_tx_s v);
    tx_out = v;
  endtask : send
endmodule : rpm_mac_model

/* dv/tb_top.sv */
// Self-checking bench for the pin mux block
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rpm_pkg::*;
  logic clk_in, resetn_in, variant, rx_err, receive_error_out_pin, wake_ev, b;
  logic [7:0] event_v;
  logic mdc, mac_mdio, mac_oe, mdio_w, dev_mdio, dev_oe, txd1_w;
  logic ref_clk, ref_oe, receive_error_out_out, receive_error_out_oe, wake_en, int_pin, int_oe, t1_out, t1_oe;
  rpm_tx_s mac_tx, dev_tx;
  logic [15:0] rd;
  int fails, check_count;

  // Pull-up on the management wire, device wins on the data pin
  assign mdio_w = dev_oe ? dev_mdio : (mac_oe ? mac_mdio : 1'b1);
  assign txd1_w = t1_oe ? t1_out : mac_tx.data[1];

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  rpm_mac_model mac (.mdc_out(mdc), .mac_mdio_out(mac_mdio), .mac_oe_out(mac_oe),
    .mdio_in(mdio_w), .tx_out(mac_tx));

  rpm_pin_mux dut (.clk_in(clk_in), .resetn_in(resetn_in), .mdc_in(mdc), .mdio_in(mdio_w),
    .mdio_out(dev_mdio), .mdio_oe_out(dev_oe), .clock_variant_in(variant),
    .ref_clk_out(ref_clk), .ref_clk_oe_out(ref_oe), .rx_error_in(rx_err),
    .receive_error_out_pin_in(receive_error_out_pin), .receive_error_out(receive_error_out_out), .receive_error_oe_out(receive_error_out_oe),
    .wake_output_enable_strap_out(wake_en), .event_in(event_v), .wake_event_in(wake_ev),
    .interrupt_pin_out(int_pin), .interrupt_pin_oe_out(int_oe), .txen_in(mac_tx.en),
    .txd0_in(mac_tx.data[0]), .txd1_in(txd1_w), .txd1_out(t1_out), .txd1_oe_out(t1_oe),
    .tx_out(dev_tx));

  task automatic complete_run;
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] x;
    mac.frame(OP_WRITE, a, d, x);
    cyc(10);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    mac.frame(OP_READ, a, 16'h0000, rd);
    `CHK(rd, e)
    cyc(10);
  endtask : rdc

  // Straps held through the 12-cycle reset, management clock runs meanwhile
  task automatic do_reset(input logic v, input logic p);
    resetn_in = 1'b0;
    variant = v;
    receive_error_out_pin = p;
    fork
      mac.pulses(4);
      cyc(12);
    join
    resetn_in = 1'b1;
    // Management reset sync needs a few edges before the first frame
    mac.pulses(3);
    cyc(4);
  endtask : do_reset

  task automatic pulse_event(input logic [7:0] v);
    event_v = v;
    cyc(1);
    event_v = 8'h00;
    cyc(2);
  endtask : pulse_event

  initial begin
    #500000;
    fails++;
    complete_run();
  end

  initial begin
    resetn_in = 1'b0;
    variant = 1'b0;
    rx_err = 1'b0;
    receive_error_out_pin = 1'b0;
    wake_ev = 1'b0;
    event_v = 8'h00;
    fails = 0;
    check_count = 0;
    do_reset(1'b0, 1'b1);
    `CHK(ref_oe, 1'b1)
    b = ref_clk;
    cyc(1);
    `CHK(ref_clk, ~b)
    `CHK(wake_en, 1'b1)
    `CHK(receive_error_out_oe, 1'b1)
    rdc(ADDR_CTL2, CTL2_RST);
    rdc(ADDR_ICSR, 16'h0000);
    rdc(5'h02, 16'h0000);
    wr(ADDR_CTL2, 16'h0080);
    `CHK(ref_oe, 1'b0)
    rdc(ADDR_CTL2, 16'h0080);
    wr(ADDR_CTL2, 16'h0000);
    `CHK(ref_oe, 1'b1)
    // Receive error passes one cycle later
    rx_err = 1'b1;
    cyc(1);
    `CHK(receive_error_out_out, 1'b1)
    rx_err = 1'b0;
    cyc(1);
    `CHK(receive_error_out_out, 1'b0)
    // Disabled cause stays silent, enabled one drives the pin low
    wr(ADDR_ICSR, 16'h0100);
    pulse_event(8'h02);
    `CHK(int_oe, 1'b0)
    pulse_event(8'h01);
    `CHK(int_oe, 1'b1)
    `CHK(int_pin, 1'b0)
    cyc(20);
    `CHK(int_oe, 1'b1)
    rdc(ADDR_ICSR, 16'h0103);
    `CHK(int_oe, 1'b0)
    rdc(ADDR_ICSR, 16'h0100);
    // Active high polarity
    wr(ADDR_CTL2, 16'h0200);
    `CHK({int_oe, int_pin}, 2'b10)
    pulse_event(8'h01);
    `CHK(int_pin, 1'b1)
    rdc(ADDR_ICSR, 16'h0101);
    `CHK(int_pin, 1'b0)
    // Wake option two with the strap enabled
    wr(ADDR_CTL2, 16'h0400);
    `CHK(int_oe, 1'b0)
    wake_ev = 1'b1;
    cyc(1);
    wake_ev = 1'b0;
    cyc(3);
    `CHK({int_oe, int_pin}, 2'b10)
    rdc(ADDR_ICSR, 16'h0100);
    `CHK(int_oe, 1'b0)
    // Transmit pins reach the core
    mac.send(rpm_tx_s'(3'b110));
    for (int i = 0; i < 10 && dev_tx.en !== 1'b1; i++) cyc(1);
    if (dev_tx.en !== 1'b1) begin
      fails++;
      complete_run();
    end
    `CHK(dev_tx, rpm_tx_s'(3'b110))
    // Test mode turns the data pin round
    wr(ADDR_CTL2, 16'h0800);
    `CHK(t1_oe, 1'b1)
    `CHK(dev_tx.data[1], 1'b0)
    // Enable low and data zero high settle the chain output high
    mac.send(rpm_tx_s'(3'b001));
    cyc(10);
    `CHK(t1_out, 1'b1)
    wr(ADDR_CTL2, 16'h0000);
    `CHK(t1_oe, 1'b0)
    // External clock variant, wake strap low
    do_reset(1'b1, 1'b0);
    `CHK(ref_oe, 1'b0)
    `CHK(wake_en, 1'b0)
    rdc(ADDR_CTL2, 16'h0080);
    complete_run();
  end
endmodule : tb_top
